// ===== rtl/csitx_pkg.sv
// Shared constants, carriers and state types of the camera-serial transmit port.
package csitx_pkg;

	// Lane count encodings
	localparam logic [1:0] LANES_ONE = 2'h0;
	localparam logic [1:0] LANES_TWO = 2'h1;
	localparam logic [1:0] LANES_FOUR = 2'h3;
	localparam int DATA_LANES = 4;
	localparam int CLOCK_LANE = 4;

	// Short packet data types
	localparam logic [5:0] DT_FRAME_START = 6'h00;
	localparam logic [5:0] DT_FRAME_END = 6'h01;
	localparam logic [5:0] DT_LINE_START = 6'h02;
	localparam logic [5:0] DT_LINE_END = 6'h03;

	// Lane byte stream framing
	localparam logic [7:0] HS_SYNC_BYTE = 8'hB8;
	localparam logic [7:0] HS_TRAIL_BYTE = 8'h00;
	localparam logic [16:0] HDR_BYTES = 17'h00004;
	localparam logic [16:0] FTR_BYTES = 17'h00002;
	localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
	localparam logic [7:0] PPC_DEFAULT = 8'h08;

	// Documented link figures
	localparam int LANE_RATE_MBPS = 1500;
	localparam int LOW_POWER_CLOCK_MIN_MHZ = 11;
	localparam int LOW_POWER_CLOCK_MAX_MHZ = 20;
	localparam int SLEEP_PULSE_MIN_NS = 5000;

	typedef struct packed {
		logic frame_sync;
		logic line_sync;
		logic valid;
		logic [63:0] data;
	} csitx_video_t;

	typedef struct packed {
		logic [1:0] vc;
		logic [5:0] dt;
		logic [15:0] wc;
	} csitx_hdr_t;

	typedef struct packed {
		logic vld;
		logic [7:0] data;
	} csitx_byte_t;

	typedef enum logic [1:0] {TX_IDLE, TX_SOT, TX_BODY, TX_EOT} csitx_tx_state_t;

	// Pixels carried by one 64-bit word for each video type
	function automatic logic [7:0] pixels_per_word(input logic [5:0] dt);
		unique case (dt)
			6'h20, 6'h21, 6'h22, 6'h2D: pixels_per_word = 8'h04;
			6'h23: pixels_per_word = 8'h03;
			6'h24: pixels_per_word = 8'h02;
			6'h28: pixels_per_word = 8'h0A;
			6'h29, 6'h2A: pixels_per_word = 8'h08;
			6'h2B: pixels_per_word = 8'h06;
			6'h2C: pixels_per_word = 8'h05;
			default: pixels_per_word = PPC_DEFAULT;
		endcase
	endfunction

	function automatic logic [15:0] word_byte_sum(input logic [63:0] w);
		logic [15:0] s;
		s = 16'h0000;
		for (int i = 0; i < 8; i++) begin
			s = s + {8'h00, w[i*8 +: 8]};
		end
		return s;
	endfunction

endpackage

// ===== rtl/csitx_lane.sv
// One high-speed data lane: byte serialiser and pad state.
`timescale 1ns/1ps
module csitx_lane (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic load_i,
	input wire csitx_pkg::csitx_byte_t byte_i,
	input wire logic asleep_i,
	output logic pad_pos_o,
	output logic pad_neg_o,
	output logic hs_o
);

	logic [7:0] shreg;

	wire [7:0] next_shreg = load_i ? byte_i.data : {1'b0, shreg[7:1]};
	wire next_hs = load_i ? byte_i.vld : hs_o;

	// Idle lane sits at stop state, a sleeping lane drives both pads low
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			shreg <= 8'h00;
			hs_o <= 1'b0;
			pad_pos_o <= 1'b1;
			pad_neg_o <= 1'b1;
		end else begin
			shreg <= next_shreg;
			hs_o <= next_hs;
			pad_pos_o <= next_hs ? next_shreg[0] : ~asleep_i;
			pad_neg_o <= next_hs ? ~next_shreg[0] : ~asleep_i;
		end
	end

	property p_lane_diff;
		@(posedge ref_clk_i) disable iff (rst_i)
		hs_o |-> (pad_pos_o != pad_neg_o);
	endproperty
	a_lane_diff: assert property (p_lane_diff) else $error("lane pads not complementary in HS");

endmodule

// ===== rtl/csitx_sleep.sv
// Low-power sleep state of one lane, on the escape clock.
`timescale 1ns/1ps
module csitx_sleep (
	input wire logic low_power_clock_i,
	input wire logic rst_i,
	input wire logic enter_i,
	input wire logic exit_i,
	output logic asleep_o
);

	logic [1:0] enter_s;
	logic [1:0] exit_s;

	wire go_sleep = enter_s[1] & ~exit_s[1];
	wire go_wake = exit_s[1] & ~enter_s[1];

	// Both requests high is illegal; the state then simply holds
	always_ff @(posedge low_power_clock_i or posedge rst_i) begin
		if (rst_i) begin
			enter_s <= 2'h0;
			exit_s <= 2'h0;
			asleep_o <= 1'b0;
		end else begin
			enter_s <= {enter_s[0], enter_i};
			exit_s <= {exit_s[0], exit_i};
			if (go_sleep) begin
				asleep_o <= 1'b1;
			end else if (go_wake) begin
				asleep_o <= 1'b0;
			end
		end
	end

endmodule

// ===== rtl/csitx_port.sv
// Camera-serial video transmit port: packetiser, lane distribution and pads.
`timescale 1ns/1ps
module csitx_port #(
	parameter int LINE_WORDS = 1024,
	parameter int PLL_LOCK_EDGES = 16
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic low_power_clock_i,
	input wire logic shared_pll_ref_input_i,
	input wire logic lane_layer_reset_n_i,
	input wire logic packetiser_reset_n_i,
	input wire logic [1:0] lane_count_i,
	input wire logic framing_accurate_i,
	input wire logic continuous_clock_i,
	input wire csitx_pkg::csitx_video_t video_i,
	input wire logic [15:0] line_width_i,
	input wire logic [5:0] data_type_i,
	input wire logic [1:0] virtual_channel_id_i,
	input wire logic clock_lane_sleep_request_i,
	input wire logic clock_lane_wake_request_i,
	input wire logic [3:0] data_lane_sleep_request_i,
	input wire logic [3:0] data_lane_wake_request_i,
	output logic [4:0] lane_pad_pos_o,
	output logic [4:0] lane_pad_neg_o,
	output logic pll_locked_o,
	output logic line_overrun_o,
	output logic busy_o
);

	localparam int AW = $clog2(LINE_WORDS);
	localparam logic [AW:0] DEPTH = LINE_WORDS[AW:0];
	localparam logic [7:0] LOCK_EDGES = PLL_LOCK_EDGES[7:0];

	if (LINE_WORDS < 2 || LINE_WORDS > 8190) begin : g_bad_depth
		$error("LINE_WORDS must lie in 2..8190");
	end
	if (PLL_LOCK_EDGES < 1 || PLL_LOCK_EDGES > 255) begin : g_bad_lock
		$error("PLL_LOCK_EDGES must lie in 1..255");
	end

	// Either reset input alone resets its layer; both tie high when unused
	wire ctl_rst = sys_rst_i | ~packetiser_reset_n_i;
	wire phy_rst = sys_rst_i | ~lane_layer_reset_n_i;

	// Mode pins are only legal to change in reset, so take them once after release
	logic cfg_loaded;
	logic [1:0] lanes_cfg;
	logic accurate_cfg;
	logic continuous_cfg;

	always_ff @(posedge ref_clk_i or posedge ctl_rst) begin
		if (ctl_rst) begin
			cfg_loaded <= 1'b0;
			lanes_cfg <= csitx_pkg::LANES_ONE;
			accurate_cfg <= 1'b0;
			continuous_cfg <= 1'b0;
		end else if (!cfg_loaded) begin
			cfg_loaded <= 1'b1;
			lanes_cfg <= lane_count_i;
			accurate_cfg <= framing_accurate_i;
			continuous_cfg <= continuous_clock_i;
		end
	end

	// Code 10 is undefined and falls back to one lane
	wire [3:0] lane_en = (lanes_cfg == csitx_pkg::LANES_FOUR) ? 4'hF :
		(lanes_cfg == csitx_pkg::LANES_TWO) ? 4'h3 : 4'h1;
	wire [16:0] lane_num = (lanes_cfg == csitx_pkg::LANES_FOUR) ? 17'h00004 :
		(lanes_cfg == csitx_pkg::LANES_TWO) ? 17'h00002 : 17'h00001;

	// Video inputs share this clock and need no synchroniser
	logic frame_d;
	logic line_d;
	wire frame_rise = video_i.frame_sync & ~frame_d;
	wire frame_fall = ~video_i.frame_sync & frame_d;
	wire line_rise = video_i.line_sync & ~line_d;
	wire line_fall = ~video_i.line_sync & line_d;

	logic [63:0] mem [LINE_WORDS];
	logic [1:0] frame_vc;
	logic capturing;
	logic line_ready;
	logic [AW:0] wr_ptr;
	logic [15:0] pix_cnt;
	logic [15:0] width_lat;
	logic [5:0] dt_lat;
	logic [15:0] sum_acc;
	logic [AW:0] line_words;
	logic [5:0] line_dt;
	logic [15:0] line_sum;
	logic fs_pend;
	logic fe_pend;
	logic ls_pend;
	logic le_pend;
	logic line_done;

	// One buffered line: a new line arriving before the last one left is dropped
	wire cap_now = line_rise ? ~line_ready : capturing;
	wire [AW:0] wr_base = line_rise ? '0 : wr_ptr;
	wire [15:0] pix_base = line_rise ? 16'h0000 : pix_cnt;
	wire [15:0] sum_base = line_rise ? 16'h0000 : sum_acc;
	wire [15:0] width_now = line_rise ? line_width_i : width_lat;
	wire [7:0] ppc = csitx_pkg::pixels_per_word(line_rise ? data_type_i : dt_lat);
	wire room = (wr_base < DEPTH) && (pix_base < width_now);
	wire wr_en = video_i.line_sync & video_i.valid & cap_now & room;

	always_ff @(posedge ref_clk_i) begin
		if (wr_en) begin
			mem[wr_base[AW-1:0]] <= video_i.data;
		end
	end

	always_ff @(posedge ref_clk_i or posedge ctl_rst) begin
		if (ctl_rst) begin
			frame_d <= 1'b0;
			line_d <= 1'b0;
			frame_vc <= 2'h0;
			capturing <= 1'b0;
			wr_ptr <= '0;
			pix_cnt <= 16'h0000;
			width_lat <= 16'h0000;
			dt_lat <= 6'h00;
			sum_acc <= 16'h0000;
			line_words <= '0;
			line_dt <= 6'h00;
			line_sum <= 16'h0000;
			line_overrun_o <= 1'b0;
		end else begin
			frame_d <= video_i.frame_sync;
			line_d <= video_i.line_sync;
			if (frame_rise) begin
				frame_vc <= virtual_channel_id_i;
			end
			if (line_rise) begin
				width_lat <= line_width_i;
				dt_lat <= data_type_i;
				capturing <= ~line_ready;
				line_overrun_o <= line_overrun_o | line_ready;
			end
			wr_ptr <= wr_en ? wr_base + 1'b1 : wr_base;
			pix_cnt <= wr_en ? pix_base + {8'h00, ppc} : pix_base;
			sum_acc <= wr_en ? sum_base + csitx_pkg::word_byte_sum(video_i.data) : sum_base;
			if (line_fall && capturing) begin
				line_words <= wr_ptr;
				line_dt <= dt_lat;
				line_sum <= sum_acc;
				capturing <= 1'b0;
			end
		end
	end

	// Packet transmit engine
	csitx_pkg::csitx_tx_state_t state;
	csitx_pkg::csitx_tx_state_t next_state;
	csitx_pkg::csitx_hdr_t cur_hdr;
	logic cur_long;
	logic [16:0] cur_total;
	logic [16:0] idx;
	logic [16:0] next_idx;
	logic [2:0] bit_cnt;
	logic [3:0] data_asleep;
	logic clk_asleep;
	logic [3:0] lane_hs;

	wire strobe = (bit_cnt == csitx_pkg::BYTE_LAST_BIT);
	wire lanes_awake = (data_asleep & lane_en) == 4'h0;
	wire can_start = pll_locked_o & lanes_awake & ~clk_asleep;
	wire any_pend = fs_pend | ls_pend | line_ready | le_pend | fe_pend;
	wire start = strobe & (state == csitx_pkg::TX_IDLE) & any_pend & can_start;

	// Priority keeps frame start first and frame end after any pending line
	wire pick_fs = fs_pend;
	wire pick_ls = ~fs_pend & ls_pend;
	wire pick_line = ~fs_pend & ~ls_pend & line_ready;
	wire pick_le = ~fs_pend & ~ls_pend & ~line_ready & le_pend;
	wire pick_fe = ~fs_pend & ~ls_pend & ~line_ready & ~le_pend;
	wire [5:0] pick_dt = pick_fs ? csitx_pkg::DT_FRAME_START : pick_ls ? csitx_pkg::DT_LINE_START :
		pick_line ? line_dt : pick_le ? csitx_pkg::DT_LINE_END : csitx_pkg::DT_FRAME_END;
	wire [15:0] pick_wc = pick_line ? 16'({line_words, 3'b000}) : 16'h0000;
	wire [16:0] pick_total = pick_line ? {1'b0, pick_wc} + csitx_pkg::HDR_BYTES + csitx_pkg::FTR_BYTES :
		csitx_pkg::HDR_BYTES;

	// Flags set by the video side win over a same-cycle take
	always_ff @(posedge ref_clk_i or posedge ctl_rst) begin
		if (ctl_rst) begin
			fs_pend <= 1'b0;
			fe_pend <= 1'b0;
			ls_pend <= 1'b0;
			le_pend <= 1'b0;
			line_ready <= 1'b0;
		end else begin
			fs_pend <= frame_rise | (fs_pend & ~(start & pick_fs));
			fe_pend <= frame_fall | (fe_pend & ~(start & pick_fe));
			ls_pend <= (line_rise & accurate_cfg & ~line_ready) | (ls_pend & ~(start & pick_ls));
			le_pend <= (line_fall & capturing & accurate_cfg) | (le_pend & ~(start & pick_le));
			line_ready <= (line_fall & capturing) | (line_ready & ~line_done);
		end
	end

	always_comb begin
		next_state = state;
		next_idx = idx;
		if (strobe) begin
			unique case (state)
				csitx_pkg::TX_IDLE: begin
					if (start) begin
						next_state = csitx_pkg::TX_SOT;
					end
				end
				csitx_pkg::TX_SOT: begin
					next_state = csitx_pkg::TX_BODY;
					next_idx = 17'h00000;
				end
				csitx_pkg::TX_BODY: begin
					if (idx + lane_num >= cur_total) begin
						next_state = csitx_pkg::TX_EOT;
					end else begin
						next_idx = idx + lane_num;
					end
				end
				csitx_pkg::TX_EOT: begin
					next_state = csitx_pkg::TX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or posedge ctl_rst) begin
		if (ctl_rst) begin
			state <= csitx_pkg::TX_IDLE;
			idx <= 17'h00000;
			bit_cnt <= 3'h0;
			cur_hdr <= '0;
			cur_long <= 1'b0;
			cur_total <= csitx_pkg::HDR_BYTES;
			line_done <= 1'b0;
		end else begin
			state <= next_state;
			idx <= next_idx;
			bit_cnt <= bit_cnt + 3'h1;
			line_done <= strobe & (state == csitx_pkg::TX_EOT) & cur_long;
			if (start) begin
				cur_hdr <= '{vc: frame_vc, dt: pick_dt, wc: pick_wc};
				cur_long <= pick_line;
				cur_total <= pick_total;
			end
		end
	end

	assign busy_o = (state != csitx_pkg::TX_IDLE);

	wire [7:0] hdr_b0 = {cur_hdr.vc, cur_hdr.dt};
	wire [7:0] hdr_b1 = cur_hdr.wc[7:0];
	wire [7:0] hdr_b2 = cur_hdr.wc[15:8];
	wire [7:0] hdr_b3 = hdr_b0 ^ hdr_b1 ^ hdr_b2;
	wire [16:0] pay_end = csitx_pkg::HDR_BYTES + {1'b0, cur_hdr.wc};

	// Lanes are fed from the packet stream, plus the per-lane sleep state that sets their idle pads
	for (genvar l = 0; l < csitx_pkg::DATA_LANES; l++) begin : g_lane
		wire [16:0] k = next_idx + 17'(l);
		wire [16:0] off = k - csitx_pkg::HDR_BYTES;
		wire [63:0] word = mem[off[AW+2:3]];
		wire [7:0] pbyte = word[{off[2:0], 3'b000} +: 8];
		wire [7:0] hbyte = (k[1:0] == 2'h0) ? hdr_b0 : (k[1:0] == 2'h1) ? hdr_b1 :
			(k[1:0] == 2'h2) ? hdr_b2 : hdr_b3;
		wire [7:0] fbyte = (k == pay_end) ? line_sum[7:0] : line_sum[15:8];
		wire [7:0] body = (k < csitx_pkg::HDR_BYTES) ? hbyte : (!cur_long || k >= cur_total) ?
			csitx_pkg::HS_TRAIL_BYTE : (k < pay_end) ? pbyte : fbyte;
		wire [7:0] lbyte = (next_state == csitx_pkg::TX_SOT) ? csitx_pkg::HS_SYNC_BYTE :
			(next_state == csitx_pkg::TX_BODY) ? body : csitx_pkg::HS_TRAIL_BYTE;
		csitx_pkg::csitx_byte_t lane_byte;
		assign lane_byte = '{vld: lane_en[l] & (next_state != csitx_pkg::TX_IDLE), data: lbyte};

		csitx_lane u_lane (
			.ref_clk_i(ref_clk_i),
			.rst_i(phy_rst),
			.load_i(strobe),
			.byte_i(lane_byte),
			.asleep_i(data_asleep[l]),
			.pad_pos_o(lane_pad_pos_o[l]),
			.pad_neg_o(lane_pad_neg_o[l]),
			.hs_o(lane_hs[l])
		);
	end

	// Escape domain: reset released synchronously, sleep state per lane
	logic esc_rst_meta;
	logic esc_rst;
	logic [4:0] asleep_esc;
	logic [4:0] asleep_meta;
	logic [4:0] asleep_sync;
	wire [4:0] sleep_req = {clock_lane_sleep_request_i, data_lane_sleep_request_i};
	wire [4:0] wake_req = {clock_lane_wake_request_i, data_lane_wake_request_i};

	always_ff @(posedge low_power_clock_i or posedge phy_rst) begin
		if (phy_rst) begin
			esc_rst_meta <= 1'b1;
			esc_rst <= 1'b1;
		end else begin
			esc_rst_meta <= 1'b0;
			esc_rst <= esc_rst_meta;
		end
	end

	for (genvar s = 0; s <= csitx_pkg::CLOCK_LANE; s++) begin : g_sleep
		csitx_sleep u_sleep (
			.low_power_clock_i(low_power_clock_i),
			.rst_i(esc_rst),
			.enter_i(sleep_req[s]),
			.exit_i(wake_req[s]),
			.asleep_o(asleep_esc[s])
		);
	end

	// PLL reference is a foreign clock: sample it twice before edge counting
	logic [2:0] pll_s;
	logic [7:0] lock_cnt;

	always_ff @(posedge ref_clk_i or posedge phy_rst) begin
		if (phy_rst) begin
			asleep_meta <= 5'h00;
			asleep_sync <= 5'h00;
			pll_s <= 3'h0;
			lock_cnt <= 8'h00;
			pll_locked_o <= 1'b0;
		end else begin
			asleep_meta <= asleep_esc;
			asleep_sync <= asleep_meta;
			pll_s <= {pll_s[1:0], shared_pll_ref_input_i};
			if (pll_s[1] & ~pll_s[2] & ~pll_locked_o) begin
				lock_cnt <= lock_cnt + 8'h01;
			end
			pll_locked_o <= pll_locked_o | (lock_cnt >= LOCK_EDGES);
		end
	end

	assign data_asleep = asleep_sync[3:0];
	assign clk_asleep = asleep_sync[csitx_pkg::CLOCK_LANE];

	// Clock lane: high-speed clock free-running or only around packets
	logic clk_tgl;
	wire clk_hs = pll_locked_o & ~clk_asleep & (continuous_cfg | busy_o);

	always_ff @(posedge ref_clk_i or posedge phy_rst) begin
		if (phy_rst) begin
			clk_tgl <= 1'b0;
			lane_pad_pos_o[csitx_pkg::CLOCK_LANE] <= 1'b1;
			lane_pad_neg_o[csitx_pkg::CLOCK_LANE] <= 1'b1;
		end else begin
			clk_tgl <= ~clk_tgl;
			lane_pad_pos_o[csitx_pkg::CLOCK_LANE] <= clk_hs ? clk_tgl : ~clk_asleep;
			lane_pad_neg_o[csitx_pkg::CLOCK_LANE] <= clk_hs ? ~clk_tgl : ~clk_asleep;
		end
	end

	sequence s_clk_run;
		clk_hs [*2];
	endsequence
	sequence s_fs_sent;
		(state == csitx_pkg::TX_SOT) && (cur_hdr.dt == csitx_pkg::DT_FRAME_START);
	endsequence

	property p_lane_count;
		@(posedge ref_clk_i) disable iff (ctl_rst || phy_rst)
		cfg_loaded |-> ((lane_hs & ~lane_en) == 4'h0);
	endproperty
	a_lane_count: assert property (p_lane_count) else $error("disabled lane in HS");
	property p_phy_reset;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		!lane_layer_reset_n_i |-> (lane_pad_pos_o == 5'h1F) && (lane_pad_neg_o == 5'h1F);
	endproperty
	a_phy_reset: assert property (p_phy_reset) else $error("pads not at stop state in lane reset");
	property p_ctl_reset;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		!packetiser_reset_n_i |-> (state == csitx_pkg::TX_IDLE) && !line_ready && !fs_pend;
	endproperty
	a_ctl_reset: assert property (p_ctl_reset) else $error("packetiser active in reset");
	property p_fs_packet;
		@(posedge ref_clk_i) disable iff (ctl_rst || phy_rst)
		(start && fs_pend) |=> s_fs_sent;
	endproperty
	a_fs_packet: assert property (p_fs_packet) else $error("frame start not sent first");
	property p_general_frame;
		@(posedge ref_clk_i) disable iff (ctl_rst || phy_rst)
		(cfg_loaded && !accurate_cfg) |-> !ls_pend && !le_pend;
	endproperty
	a_general_frame: assert property (p_general_frame) else $error("line markers in general framing");
	property p_invalid_skip;
		@(posedge ref_clk_i) disable iff (ctl_rst || phy_rst)
		(video_i.line_sync && !video_i.valid && !line_rise) |=> (wr_ptr == $past(wr_ptr));
	endproperty
	a_invalid_skip: assert property (p_invalid_skip) else $error("word stored without valid");
	property p_word_count;
		@(posedge ref_clk_i) disable iff (ctl_rst || phy_rst)
		(wr_en && !line_rise) |=> (wr_ptr == $past(wr_ptr) + 1'b1);
	endproperty
	a_word_count: assert property (p_word_count) else $error("stored word not counted");
	property p_cont_clock;
		@(posedge ref_clk_i) disable iff (ctl_rst || phy_rst)
		s_clk_run |=> (lane_pad_pos_o[4] != $past(lane_pad_pos_o[4]));
	endproperty
	a_cont_clock: assert property (p_cont_clock) else $error("clock lane not toggling");
	property p_byte_time;
		@(posedge ref_clk_i) disable iff (ctl_rst || phy_rst)
		strobe |=> !strobe [*7] ##1 strobe;
	endproperty
	a_byte_time: assert property (p_byte_time) else $error("lane byte time not 8 cycles");

endmodule

// ===== test/csitx_rx_model.sv
// Board receiver model of one high-speed data lane.
`timescale 1ns/1ps
module csitx_rx_model (
	input wire logic ref_clk_i,
	input wire logic pad_pos_i,
	input wire logic pad_neg_i,
	output logic [7:0] byte_o,
	output logic stb_o
);
	logic [7:0] sh;
	logic [2:0] cnt;
	wire logic hs = pad_pos_i ^ pad_neg_i;
	initial begin
		cnt = 3'h0;
		stb_o = 1'b0;
		byte_o = 8'h00;
	end
	// Bits arrive LSB first; alignment restarts at every burst
	always @(posedge ref_clk_i) begin
		stb_o <= 1'b0;
		if (hs !== 1'b1) begin
			cnt <= 3'h0;
		end else begin
			sh <= {pad_pos_i, sh[7:1]};
			cnt <= cnt + 3'h1;
			if (cnt == 3'h7) begin
				byte_o <= {pad_pos_i, sh[7:1]};
				stb_o <= 1'b1;
			end
		end
	end
endmodule

// ===== test/csitx_port_tb.sv
// Self-checking bench of the camera-serial transmit port.
`timescale 1ns/1ps
module csitx_port_tb;
	logic ref_clk_i = 1'b0, esc = 1'b0, pref = 1'b0, sys_rst_i = 1'b1, lrst_n = 1'b0, prst_n = 1'b0;
	logic [1:0] lanes = 2'h0, vc = 2'h0;
	logic acc = 1'b0, cont = 1'b0, cslp = 1'b0, cwk = 1'b0, locked, overrun, busy, s0, s1;
	logic [3:0] dslp = 4'h0, dwk = 4'h0;
	logic [4:0] pos, neg;
	logic [7:0] b0, b1;
	logic [15:0] width = 16'h0010;
	logic [5:0] dt = 6'h2A;
	logic [7:0] q0[$], q1[$], exp[$];
	logic [63:0] w[4] = '{64'h0807060504030201, 64'hFFFFFFFFFFFFFFFF, 64'h100F0E0D0C0B0A09, 64'hEEEEEEEEEEEEEEEE};
	csitx_pkg::csitx_video_t vid = '0;
	int n_errors = 0, cmp_count = 0, cyc = 0;
	csitx_port #(.LINE_WORDS(16), .PLL_LOCK_EDGES(2)) DUT (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.low_power_clock_i(esc), .shared_pll_ref_input_i(pref), .lane_layer_reset_n_i(lrst_n),
		.packetiser_reset_n_i(prst_n), .lane_count_i(lanes), .framing_accurate_i(acc), .continuous_clock_i(cont),
		.video_i(vid), .line_width_i(width), .data_type_i(dt), .virtual_channel_id_i(vc),
		.clock_lane_sleep_request_i(cslp), .clock_lane_wake_request_i(cwk), .data_lane_sleep_request_i(dslp),
		.data_lane_wake_request_i(dwk), .lane_pad_pos_o(pos), .lane_pad_neg_o(neg), .pll_locked_o(locked),
		.line_overrun_o(overrun), .busy_o(busy));
	csitx_rx_model rx0 (.ref_clk_i(ref_clk_i), .pad_pos_i(pos[0]), .pad_neg_i(neg[0]), .byte_o(b0), .stb_o(s0));
	csitx_rx_model rx1 (.ref_clk_i(ref_clk_i), .pad_pos_i(pos[1]), .pad_neg_i(neg[1]), .byte_o(b1), .stb_o(s1));
	initial forever #5 ref_clk_i = ~ref_clk_i;
	initial forever #20 pref = ~pref;
	initial begin
		#13;
		forever #40 esc = ~esc;
	end
	always @(posedge ref_clk_i) begin
		if (s0) q0.push_back(b0);
		if (s1) q1.push_back(b1);
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			give_verdict();
		end
	end
	task give_verdict;
		if (n_errors == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task chk(input string what, input logic [63:0] e, input logic [63:0] s);
		cmp_count++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, e, s);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	task wait_q(input int lane, input int n);
		for (int i = 0; i < 3000 && (lane ? q1.size() : q0.size()) < n; i++) tick(1);
	endtask
	task wait_lock;
		for (int i = 0; i < 300 && locked !== 1'b1; i++) tick(1);
		chk("pll locked", 1, locked);
	endtask
	task t_frame;
		vc = 2'h2;
		tick(1);
		vid.frame_sync = 1'b1;
		tick(3);
		vid.line_sync = 1'b1;
		// Invalid word skipped, last valid word beyond line width dropped
		for (int k = 0; k < 4; k++) begin
			vid.valid = (k != 1);
			vid.data = w[k];
			tick(1);
		end
		vid.line_sync = 1'b0;
		vid.valid = 1'b0;
		tick(4);
		vid.frame_sync = 1'b0;
		exp = {8'hB8, 8'h80, 8'h00, 8'h00, 8'h80, 8'h00, 8'hB8, 8'hAA, 8'h10, 8'h00, 8'hBA};
		for (int i = 1; i <= 16; i++) exp.push_back(8'(i));
		exp = {exp, 8'h88, 8'h00, 8'h00, 8'hB8, 8'h81, 8'h00, 8'h00, 8'h81, 8'h00};
		wait_q(0, exp.size());
		tick(60);
		chk("lane0 byte count", exp.size(), q0.size());
		for (int i = 0; i < exp.size() && i < q0.size(); i++) chk("lane0 byte", exp[i], q0[i]);
		chk("overrun", 0, overrun);
		q0.delete();
	endtask
	task t_sleep;
		dslp = 4'h1;
		cslp = 1'b1;
		tick(500);
		chk("pads asleep", 10'h1CE, {pos, neg});
		dslp = 4'h0;
		cslp = 1'b0;
		vid.frame_sync = 1'b1;
		tick(100);
		chk("bytes while asleep", 0, q0.size());
		dwk = 4'h1;
		cwk = 1'b1;
		tick(500);
		dwk = 4'h0;
		cwk = 1'b0;
		wait_q(0, 6);
		chk("start after wake", 8'h80, q0[1]);
		vid.frame_sync = 1'b0;
		wait_q(0, 12);
		tick(20);
		chk("pads awake", 10'h3FF, {pos, neg});
	endtask
	task t_two_lane;
		logic clk_prev;
		prst_n = 1'b0;
		lrst_n = 1'b0;
		lanes = 2'h1;
		acc = 1'b1;
		cont = 1'b1;
		tick(2);
		chk("pads in reset", 10'h3FF, {pos, neg});
		chk("busy in reset", 0, busy);
		tick(20);
		prst_n = 1'b1;
		lrst_n = 1'b1;
		q0.delete();
		q1.delete();
		wait_lock();
		// Continuous mode: clock lane toggles with nothing to send
		tick(1);
		clk_prev = pos[4];
		tick(1);
		chk("clock lane toggle", 1, pos[4] ^ clk_prev);
		vc = 2'h1;
		tick(1);
		vid.frame_sync = 1'b1;
		tick(3);
		vid.line_sync = 1'b1;
		vid.valid = 1'b1;
		vid.data = w[0];
		tick(1);
		vid.line_sync = 1'b0;
		vid.valid = 1'b0;
		wait_q(1, 8);
		chk("lane1 start ecc", 8'h40, q1[2]);
		chk("lane0 line start", 8'h42, q0[5]);
		chk("lane1 line start", 8'h42, q1[6]);
		chk("lane2 idle", 2'h3, {pos[2], neg[2]});
		// A second line while the first is still queued is dropped
		vid.line_sync = 1'b1;
		tick(1);
		vid.line_sync = 1'b0;
		tick(2);
		chk("overrun", 1, overrun);
	endtask
	initial begin
		tick(2);
		sys_rst_i = 1'b0;
		tick(18);
		lrst_n = 1'b1;
		prst_n = 1'b1;
		wait_lock();
		t_frame();
		t_sleep();
		t_two_lane();
		give_verdict();
	end
endmodule
